// [pkg/smsb_pkg.sv]
// constants for the safety monitor status register bank
// assumes a 32-bit classic wishbone slave with word-aligned registers
package smsb_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] SMSB_OFS_INREF  = 4'h0;
  localparam logic [3:0] SMSB_OFS_RAIL   = 4'h4;
  localparam logic [3:0] SMSB_OFS_ILTH   = 4'h8;
  localparam logic [3:0] SMSB_OFS_CRCWD  = 4'hc;
  localparam logic [3:0] SMSB_OFS_CTRL   = 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0;
  // ****************************************
  // control register fields (offset 0x10)
  // ****************************************
  localparam logic [7:0] SMSB_ADR_CTRL   = 8'h10;
  localparam int         SMSB_CTRL_CANEN = 0;
  localparam int         SMSB_CTRL_UNMSK = 1;
  localparam int         SMSB_CTRL_WDRST = 2;
  localparam logic [2:0] SMSB_CTRL_RST   = 3'h3;
  // ****************************************
  // status fields
  // ****************************************
  localparam int         SMSB_CFGCRC_BIT = 5;
  localparam int         SMSB_NVMCRC_BIT = 4;
  localparam logic [2:0] SMSB_WDCNT_RST  = 3'h5;
  localparam logic [2:0] SMSB_WDCNT_MAX  = 3'h7;
  localparam logic [2:0] SMSB_WDCNT_MIN  = 3'h0;
  localparam logic [31:0] SMSB_UNMAPPED  = 32'h0000_0000;
endpackage

// [src/smsb_status_bank.sv]
// safety monitor status bank: four read-only status registers and one control register
// assumes monitor inputs are analog comparator levels, synchronised here
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
// How it works
// [R1] battery over/undervoltage live flags at bits 7 and 6
// [R2] charge pump flags at bits 5, 4, 3, live
// [R3] bit 2 set while monitor supply not good
// [R4] bit 1 set while reference below main bandgap
// [R5] bit 0 set while reference above main bandgap
// [R6] rail register holds live ov/uv pairs for four rails
// [R7] can rail undervoltage reported even when regulator disabled
// [R8] can current limit flag bit 7, reads 1 while can enable low
// [R9] io current limit flag bit 6, live
// [R10] sensor undervoltage bit 5, overvoltage bit 4, live
// [R11] sensor overtemp bit 2 keeps sensor regulator disabled
// [R12] unmasked can overtemp sets flag, disables regulator, clears enable
// [R13] masked can overtemp only sets flag
// [R14] io overtemp bit 0 keeps io regulator disabled
// [R15] config crc error bit 5 while crc differs from expected
// [R16] config crc error cleared when nvm crc check passes
// [R17] nvm crc error bit 4 on mismatch, cleared when gone
// [R18] nvm crc error in diagnostic state requests safe state
// [R19] watchdog fail counter bits 2:0, reset and reloaded to 5
// [R20] counter up on bad or timeout, down on good event
// [R21] enable drive allowed only while counter below 5
// [R22] with reset enable, bad event at count 7 sets watchdog failure
// [R23] crc/watchdog register also reinitialised after logic self test
// [R24] counter saturates at 0 and 7
// [R25] reserved bits read zero, writes to status have no effect
module smsb_status_bank
  import smsb_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        logic_self_test_i,
  input  wire logic [7:0]  in_ref_mon_i,
  input  wire logic [7:0]  rail_mon_i,
  input  wire logic [6:0]  ilim_ot_mon_i,
  input  wire logic        cfg_crc_mismatch_i,
  input  wire logic        nvm_crc_done_i,
  input  wire logic        nvm_crc_mismatch_i,
  input  wire logic        diag_state_i,
  input  wire logic        state_entry_i,
  input  wire logic        wd_bad_i,
  input  wire logic        wd_good_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             can_reg_on_o,
  output logic             sensor_reg_on_o,
  output logic             io_reg_on_o,
  output logic             enable_drive_allow_o,
  output logic             watchdog_failure_flag_o,
  output logic             safe_request_o
);
  import smsb_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [22:0] s1;
    logic [22:0] s2;
    logic [22:0] s3;
    logic [7:0]  inref;
    logic [7:0]  rail;
    logic [7:0]  ilth;
    logic [7:0]  crcwd;
    logic [2:0]  ctrl;
    logic [31:0] dat;
    logic        ack;
    logic        can_on;
    logic        sens_on;
    logic        io_on;
    logic        enable_drive_output;
    logic        wdfail;
    logic        safe;
  } smsb_s;

  smsb_s st_r;
  smsb_s st_nxt;

  // live views after three-flop synchronisers; a change counts when stages 2 and 3 agree
  logic [22:0] live;
  logic [22:0] agree;
  logic [22:0] prev;
  logic        wr;
  logic        rd;
  logic [7:0]  adr;

  // ****************************************
  // combinational next state
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    adr    = wb_adr_i[7:0];
    wr     = wb_cyc_i && wb_stb_i && !st_r.ack && wb_we_i;
    rd     = wb_cyc_i && wb_stb_i && !st_r.ack && !wb_we_i;
    st_nxt.s1 = {in_ref_mon_i, rail_mon_i, ilim_ot_mon_i};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // filter: only take a new level when stages 2 and 3 agree
    prev  = {st_r.inref, st_r.rail, st_r.ilth[7:4], st_r.ilth[2:0]};
    agree = ~(st_r.s2 ^ st_r.s3);
    live  = (st_r.s3 & agree) | (prev & ~agree);
    st_nxt.inref = live[22:15];                                   // [R1] [R2] [R3] [R4] [R5]
    st_nxt.rail  = live[14:7];                                    // [R6] [R7]
    st_nxt.ilth[7] = live[6] | ~st_r.ctrl[SMSB_CTRL_CANEN];       // [R8]
    st_nxt.ilth[6:4] = live[5:3];                                 // [R9] [R10]
    st_nxt.ilth[3] = 1'b0;                                        // [R25]
    st_nxt.ilth[2:0] = live[2:0];                                 // [R11] [R14]
    st_nxt.sens_on = ~live[2];                                    // [R11]
    st_nxt.io_on   = ~live[0];                                    // [R14]
    // ****************************************
    // control register write
    // ****************************************
    if (wr && adr == SMSB_ADR_CTRL && wb_sel_i[0])
    begin
      st_nxt.ctrl = wb_dat_i[2:0];
    end
    // hardware clear wins over software enable, shutdown must not be undone
    if (live[1] && st_r.ctrl[SMSB_CTRL_UNMSK])
    begin
      st_nxt.ctrl[SMSB_CTRL_CANEN] = 1'b0;                        // [R12]
    end
    st_nxt.can_on = st_nxt.ctrl[SMSB_CTRL_CANEN];                 // [R12] [R13]
    // ****************************************
    // crc flags; nvm-pass clear wins over set
    // ****************************************
    st_nxt.crcwd[7:6] = 2'h0;                                     // [R25]
    st_nxt.crcwd[3]   = 1'b0;
    st_nxt.crcwd[SMSB_NVMCRC_BIT] = nvm_crc_mismatch_i;           // [R17]
    st_nxt.crcwd[SMSB_CFGCRC_BIT] = cfg_crc_mismatch_i
      && !(nvm_crc_done_i && !nvm_crc_mismatch_i);                // [R15] [R16]
    st_nxt.safe = st_r.crcwd[SMSB_NVMCRC_BIT] && diag_state_i;   // [R18]
    // ****************************************
    // watchdog fail counter
    // ****************************************
    st_nxt.wdfail = st_r.wdfail;
    if (state_entry_i)
    begin
      st_nxt.crcwd[2:0] = SMSB_WDCNT_RST;                         // [R19]
    end
    else if (wd_bad_i)
    begin
      if (st_r.crcwd[2:0] == SMSB_WDCNT_MAX)
      begin
        st_nxt.wdfail = st_r.wdfail | st_r.ctrl[SMSB_CTRL_WDRST]; // [R22]
      end
      else
      begin
        st_nxt.crcwd[2:0] = st_r.crcwd[2:0] + 3'h1;               // [R20] [R24]
      end
    end
    else if (wd_good_i && st_r.crcwd[2:0] != SMSB_WDCNT_MIN)
    begin
      st_nxt.crcwd[2:0] = st_r.crcwd[2:0] - 3'h1;                 // [R20] [R24]
    end
    st_nxt.enable_drive_output = st_nxt.crcwd[2:0] < SMSB_WDCNT_RST;           // [R21]
    // ****************************************
    // bus answer: one cycle ack, status writes ignored
    // ****************************************
    st_nxt.ack = wr || rd;
    st_nxt.dat = SMSB_UNMAPPED;
    if (rd)
    begin
      unique case (adr)
        {4'h0, SMSB_OFS_INREF}: st_nxt.dat = {24'h0, st_r.inref};
        {4'h0, SMSB_OFS_RAIL}:  st_nxt.dat = {24'h0, st_r.rail};
        {4'h0, SMSB_OFS_ILTH}:  st_nxt.dat = {24'h0, st_r.ilth};
        {4'h0, SMSB_OFS_CRCWD}: st_nxt.dat = {24'h0, st_r.crcwd}; // [R25]
        SMSB_ADR_CTRL: st_nxt.dat = {29'h0, st_r.ctrl};
        default:       st_nxt.dat = SMSB_UNMAPPED;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r       <= '0;
      st_r.ctrl  <= SMSB_CTRL_RST;
      st_r.crcwd <= {5'h0, SMSB_WDCNT_RST};                        // [R19]
      st_r.ilth  <= 8'h00;
      st_r.can_on <= 1'b1;
    end
    else if (logic_self_test_i)
    begin
      st_r       <= st_nxt;
      st_r.crcwd <= {5'h0, SMSB_WDCNT_RST};                        // [R23]
      st_r.wdfail <= 1'b0;
      st_r.enable_drive_output <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o                = st_r.dat;
  assign wb_ack_o                = st_r.ack;
  assign can_reg_on_o            = st_r.can_on;
  assign sensor_reg_on_o         = st_r.sens_on;
  assign io_reg_on_o             = st_r.io_on;
  assign enable_drive_allow_o    = st_r.enable_drive_output;
  assign watchdog_failure_flag_o = st_r.wdfail;
  assign safe_request_o          = st_r.safe;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_bad_at_max;
    wd_bad_i && !state_entry_i && !logic_self_test_i && st_r.crcwd[2:0] == 3'h7;
  endsequence

  property p_watchdog_failure_flag;
    @(posedge clk_i) disable iff (rst_i)
      s_bad_at_max and st_r.ctrl[2] |=> watchdog_failure_flag_o;
  endproperty
  a_watchdog_failure_flag: assert property (p_watchdog_failure_flag) else $error("watchdog failure not flagged"); // [R22]

  property p_reload;
    @(posedge clk_i) disable iff (rst_i)
      state_entry_i |=> st_r.crcwd[2:0] == 3'h5;
  endproperty
  a_reload: assert property (p_reload) else $error("counter not reloaded to 5"); // [R19]

  property p_enable_drive_output;
    @(posedge clk_i) disable iff (rst_i)
      enable_drive_allow_o |-> st_r.crcwd[2:0] < 3'h5;
  endproperty
  a_enable_drive_output: assert property (p_enable_drive_output) else $error("drive enabled with counter not below 5"); // [R21]

  property p_canilim;
    @(posedge clk_i) disable iff (rst_i)
      !st_r.ctrl[0] |=> st_r.ilth[7];
  endproperty
  a_canilim: assert property (p_canilim) else $error("can current flag low while disabled"); // [R8]

  property p_canot;
    @(posedge clk_i) disable iff (rst_i)
      st_r.ilth[1] && st_r.ctrl[1] && !logic_self_test_i |=> ##1 !can_reg_on_o;
  endproperty
  a_canot: assert property (p_canot) else $error("can regulator left on at overtemp"); // [R12]

  property p_ioot;
    @(posedge clk_i) disable iff (rst_i)
      st_r.ilth[0] |-> !io_reg_on_o;
  endproperty
  a_ioot: assert property (p_ioot) else $error("io regulator on during overtemp"); // [R14]

  property p_safe;
    @(posedge clk_i) disable iff (rst_i)
      st_r.crcwd[4] && diag_state_i |=> safe_request_o;
  endproperty
  a_safe: assert property (p_safe) else $error("no safe request on nvm crc error"); // [R18]

  property p_rsv;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> wb_dat_o[31:8] == 24'h0 && !st_r.crcwd[7] && !st_r.crcwd[3];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero"); // [R25]

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack not one cycle after request"); // [R25]

  property p_bat;
    @(posedge clk_i) disable iff (rst_i)
      st_r.s2[22:21] == st_r.s3[22:21] |=> st_r.inref[7:6] == $past(st_r.s3[22:21]);
  endproperty
  a_bat: assert property (p_bat) else $error("battery flags not live"); // [R1]

  property p_pump;
    @(posedge clk_i) disable iff (rst_i)
      st_r.s2[20:18] == st_r.s3[20:18] |=> st_r.inref[5:3] == $past(st_r.s3[20:18]);
  endproperty
  a_pump: assert property (p_pump) else $error("pump flags not live"); // [R2]

  property p_monsup;
    @(posedge clk_i) disable iff (rst_i)
      st_r.s2[17] == st_r.s3[17] |=> st_r.inref[2] == $past(st_r.s3[17]);
  endproperty
  a_monsup: assert property (p_monsup) else $error("monitor supply flag not live"); // [R3]

  property p_reflo;
    @(posedge clk_i) disable iff (rst_i)
      st_r.s2[16] == st_r.s3[16] |=> st_r.inref[1] == $past(st_r.s3[16]);
  endproperty
  a_reflo: assert property (p_reflo) else $error("reference low flag not live"); // [R4]

  property p_refhi;
    @(posedge clk_i) disable iff (rst_i)
      st_r.s2[15] == st_r.s3[15] |=> st_r.inref[0] == $past(st_r.s3[15]);
  endproperty
  a_refhi: assert property (p_refhi) else $error("reference high flag not live"); // [R5]

  property p_rail;
    @(posedge clk_i) disable iff (rst_i)
      st_r.s2[14:7] == st_r.s3[14:7] |=> st_r.rail == $past(st_r.s3[14:7]);
  endproperty
  a_rail: assert property (p_rail) else $error("rail flags not live"); // [R6]

  property p_canuv;
    @(posedge clk_i) disable iff (rst_i)
      !st_r.ctrl[0] && st_r.s2[11] && st_r.s3[11] |=> st_r.rail[4];
  endproperty
  a_canuv: assert property (p_canuv) else $error("can uv hidden while disabled"); // [R7]

  property p_ioilim;
    @(posedge clk_i) disable iff (rst_i)
      st_r.s2[5] == st_r.s3[5] |=> st_r.ilth[6] == $past(st_r.s3[5]);
  endproperty
  a_ioilim: assert property (p_ioilim) else $error("io current flag not live"); // [R9]

  property p_sens;
    @(posedge clk_i) disable iff (rst_i)
      st_r.s2[4:3] == st_r.s3[4:3] |=> st_r.ilth[5:4] == $past(st_r.s3[4:3]);
  endproperty
  a_sens: assert property (p_sens) else $error("sensor uv/ov flags not live"); // [R10]

  property p_sensot;
    @(posedge clk_i) disable iff (rst_i)
      st_r.ilth[2] |-> !sensor_reg_on_o;
  endproperty
  a_sensot: assert property (p_sensot) else $error("sensor regulator on at overtemp"); // [R11]

  property p_canmask;
    @(posedge clk_i) disable iff (rst_i)
      !st_r.ctrl[1] && st_r.ctrl[0] && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> can_reg_on_o;
  endproperty
  a_canmask: assert property (p_canmask) else $error("masked overtemp acted"); // [R13]

  property p_cfgcrc;
    @(posedge clk_i) disable iff (rst_i)
      cfg_crc_mismatch_i && !nvm_crc_done_i && !logic_self_test_i |=> st_r.crcwd[5];
  endproperty
  a_cfgcrc: assert property (p_cfgcrc) else $error("config crc error not set"); // [R15]

  property p_cfgclr;
    @(posedge clk_i) disable iff (rst_i)
      nvm_crc_done_i && !nvm_crc_mismatch_i |=> !st_r.crcwd[5];
  endproperty
  a_cfgclr: assert property (p_cfgclr) else $error("config crc error not cleared"); // [R16]

  property p_nvmcrc;
    @(posedge clk_i) disable iff (rst_i)
      !logic_self_test_i |=> st_r.crcwd[4] == $past(nvm_crc_mismatch_i);
  endproperty
  a_nvmcrc: assert property (p_nvmcrc) else $error("nvm crc error not live"); // [R17]

  property p_wddown;
    @(posedge clk_i) disable iff (rst_i)
      wd_good_i && !wd_bad_i && !state_entry_i && !logic_self_test_i
        && st_r.crcwd[2:0] != 3'h0 |=> st_r.crcwd[2:0] == $past(st_r.crcwd[2:0]) - 3'h1;
  endproperty
  a_wddown: assert property (p_wddown) else $error("counter not decremented"); // [R20]

  property p_logic_self_test;
    @(posedge clk_i) disable iff (rst_i)
      logic_self_test_i |=> st_r.crcwd == 8'h05 && !watchdog_failure_flag_o;
  endproperty
  a_logic_self_test: assert property (p_logic_self_test) else $error("self test did not reinitialise"); // [R23]
endmodule // smsb_status_bank

// [tb/smsb_host.sv]
// host model: classic wishbone single cycles for the bench
// assumes a slave that answers with ack on clk_i
`timescale 1ns/100ps
module smsb_host
(
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] adr_o,
  output logic      [31:0] dat_o,
  output logic      [3:0]  sel_o,
  output logic             we_o,
  output logic             cyc_o,
  output logic             stb_o,
  output int               tmo_o
);
  initial
  begin
    {adr_o, dat_o, sel_o, we_o, cyc_o, stb_o} = '0;
    tmo_o = 0;
  end
  // request held until the edge that sees ack; a bounded wait cuts a hang
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] r);
    int n;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, dat_o, sel_o} <= {2'b11, w, a, d, 4'hf};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_i !== 1'b1 && n < 50);
    if (n >= 50)
      tmo_o++;
    r = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
  endtask
endmodule // smsb_host

// [tb/smsb_status_bank_bench.sv]
// bench for the status bank: table of monitor patterns, then hand tests
// assumes the host model drives the register bus
`timescale 1ns/100ps
module smsb_status_bank_bench;
  import smsb_pkg::*;
  logic        clk_i = 0, rst_i = 1, logic_self_test_i = 0, diag_state_i = 0;
  logic        cfg_crc_mismatch_i = 0, nvm_crc_done_i = 0, nvm_crc_mismatch_i = 0;
  logic        state_entry_i = 0, wd_bad_i = 0, wd_good_i = 0;
  logic [7:0]  in_ref_mon_i = 0, rail_mon_i = 0;
  logic [6:0]  ilim_ot_mon_i = 0;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
  logic [3:0]  wb_sel_i;
  logic        wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, can_reg_on_o;
  logic        sensor_reg_on_o, io_reg_on_o, enable_drive_allow_o;
  logic        watchdog_failure_flag_o, safe_request_o;
  int          fails = 0, checks_done = 0, tmo, i;
  // can overtemp left out of the table: it clears the can enable
  logic [22:0] row [4] = '{{8'hff, 8'hff, 7'h7d}, {8'h55, 8'h55, 7'h28},
                           {8'haa, 8'haa, 7'h55}, {8'h00, 8'h00, 7'h00}};
  initial
  forever #20 clk_i = ~clk_i;
  smsb_host h (.clk_i, .ack_i(wb_ack_o), .dat_i(wb_dat_o), .adr_o(wb_adr_i),
    .dat_o(wb_dat_i), .sel_o(wb_sel_i), .we_o(wb_we_i), .cyc_o(wb_cyc_i),
    .stb_o(wb_stb_i), .tmo_o(tmo));
  smsb_status_bank i_dut (.clk_i, .rst_i, .logic_self_test_i, .in_ref_mon_i,
    .rail_mon_i, .ilim_ot_mon_i, .cfg_crc_mismatch_i, .nvm_crc_done_i,
    .nvm_crc_mismatch_i, .diag_state_i, .state_entry_i, .wd_bad_i, .wd_good_i,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
    .wb_ack_o, .can_reg_on_o, .sensor_reg_on_o, .io_reg_on_o,
    .enable_drive_allow_o, .watchdog_failure_flag_o, .safe_request_o);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    h.xfer(1'b0, {24'h0, a}, 32'h0, rd);
    chk(rd, {24'h0, e});
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    h.xfer(1'b1, {24'h0, a}, {24'h0, d}, rd);
  endtask
  // one-cycle event pulses, an idle cycle between them
  task wd(input logic b, input logic g, input logic e, input int n);
    repeat (n)
    begin
      {wd_bad_i, wd_good_i, state_entry_i} <= {b, g, e};
      tick(1);
      {wd_bad_i, wd_good_i, state_entry_i} <= 3'h0;
      tick(1);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails + tmo);
    if (fails + tmo == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    tick(20000);
    fails++;
    complete_run;
  end
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    tick(6);
    rst_i <= 1'b0;
    rdc(8'h00, 8'h00);
    rdc(8'h0c, 8'h05);
    rdc(8'h10, 8'h03);
    rdc(8'h14, 8'h00);
    $display("test reset done");
    for (i = 0; i < 4; i++)
    begin
      {in_ref_mon_i, rail_mon_i, ilim_ot_mon_i} <= row[i];
      tick(6);
      rdc(8'h00, row[i][22:15]);
      rdc(8'h04, row[i][14:7]);
      rdc(8'h08, {row[i][6:3], 1'b0, row[i][2:0]});
      chk({sensor_reg_on_o, io_reg_on_o}, {~row[i][2], ~row[i][0]});
    end
    $display("test table done");
    wr(8'h00, 8'hff);
    rdc(8'h00, 8'h00);
    wr(8'h10, 8'h02);
    rail_mon_i <= 8'h10;
    tick(6);
    rdc(8'h04, 8'h10);
    rdc(8'h08, 8'h80);
    wr(8'h10, 8'h01);
    ilim_ot_mon_i <= 7'h02;
    tick(6);
    rdc(8'h08, 8'h02);
    rdc(8'h10, 8'h01);
    chk(can_reg_on_o, 1'b1);
    wr(8'h10, 8'h03);
    tick(2);
    rdc(8'h10, 8'h02);
    rdc(8'h08, 8'h82);
    chk(can_reg_on_o, 1'b0);
    ilim_ot_mon_i <= 7'h00;
    $display("test can rail done");
    cfg_crc_mismatch_i <= 1'b1;
    rdc(8'h0c, 8'h25);
    {cfg_crc_mismatch_i, nvm_crc_mismatch_i, diag_state_i} <= 3'h3;
    tick(3);
    chk(safe_request_o, 1'b1);
    rdc(8'h0c, 8'h15);
    {nvm_crc_mismatch_i, diag_state_i} <= 2'h0;
    rdc(8'h0c, 8'h05);
    {cfg_crc_mismatch_i, nvm_crc_done_i} <= 2'h3;
    rdc(8'h0c, 8'h05);
    {cfg_crc_mismatch_i, nvm_crc_done_i} <= 2'h0;
    $display("test crc done");
    wd(1'b1, 1'b0, 1'b0, 3);
    rdc(8'h0c, 8'h07);
    chk(enable_drive_allow_o, 1'b0);
    chk(watchdog_failure_flag_o, 1'b0);
    wr(8'h10, 8'h07);
    wd(1'b1, 1'b0, 1'b0, 1);
    tick(1);
    chk(watchdog_failure_flag_o, 1'b1);
    wd(1'b0, 1'b1, 1'b0, 8);
    rdc(8'h0c, 8'h00);
    chk(enable_drive_allow_o, 1'b1);
    wd(1'b0, 1'b0, 1'b1, 1);
    rdc(8'h0c, 8'h05);
    wd(1'b1, 1'b0, 1'b0, 1);
    logic_self_test_i <= 1'b1;
    tick(1);
    logic_self_test_i <= 1'b0;
    rdc(8'h0c, 8'h05);
    chk(watchdog_failure_flag_o, 1'b0);
    $display("test watchdog done");
    complete_run;
  end
endmodule // smsb_status_bank_bench
